/* File: design/rsx_read_stream.sv */
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module rsx_read_stream
   import rsx_pkg::*;
(
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           reset_n,
   // Register bus
   input  rsx_pkg::rsx_axil_req_s axiReq,
   output rsx_pkg::rsx_axil_rsp_s axiRsp,
   // Media engine
   output rsx_pkg::rsx_sec_req_s  secReq,
   input  rsx_pkg::rsx_sec_rsp_s  secRsp,
   // Interrupt
   output logic                irq
);

   // ==========================================================
   // Helpers
   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] errLog(input logic [3:0] e);
      logic [7:0] r;
      r = 8'h00;
      r[ER_CRC] = e[0];
      r[ER_UNC] = e[1];
      r[ER_IDN] = e[2];
      r[ER_ABT] = e[3];
      return r;
   endfunction

   // ==========================================================
   // State
   rsx_state_e  state_q;
   logic        awValid_q, wValid_q, bValid_q, rValid_q;
   logic [7:0]  awAddr_q;
   logic [31:0] wData_q, rData_q;
   logic [3:0]  wStrb_q;
   logic [1:0]  bResp_q, rResp_q;
   logic [15:0] feat_q, count_q;
   logic [23:0] lbaCur_q, lbaPrev_q;
   logic [7:0]  status_q, error_q;
   logic [47:0] resLba_q, lba_q;
   logic [15:0] resCount_q;
   logic [31:0] unit_q, minCctl_q;
   logic [2:0]  irqStat_q, irqMask_q;
   logic [16:0] remain_q;
   logic        rc_q, seenErr_q, runOpen_q;
   logic [6:0]  usDiv_q;
   logic [39:0] elapsed_q, limit_q;
   logic        limitOn_q;
   logic [7:0]  dfltCctl;

   // ==========================================================
   // Bus decode
   wire         wrEn    = awValid_q && wValid_q && !bValid_q;
   wire [31:0]  wMerge  = mergeBytes(32'h0, wData_q, wStrb_q);
   wire         wrFeat  = wrEn && awAddr_q == OFF_FEAT;
   wire         wrCount = wrEn && awAddr_q == OFF_COUNT;
   wire         wrLbaC  = wrEn && awAddr_q == OFF_LBA_CUR;
   wire         wrLbaP  = wrEn && awAddr_q == OFF_LBA_PREV;
   wire         wrCmd   = wrEn && awAddr_q == OFF_COMMAND && wStrb_q[0];
   wire         wrUnit  = wrEn && awAddr_q == OFF_UNIT_TIME;
   wire         wrMin   = wrEn && awAddr_q == OFF_MIN_CCTL;
   wire         wrCfg   = wrEn && awAddr_q == OFF_STREAM_CFG;
   wire         wrIStat = wrEn && awAddr_q == OFF_IRQ_STAT;
   wire         wrIMask = wrEn && awAddr_q == OFF_IRQ_MASK;
   wire         wrHit   = wrFeat || wrCount || wrLbaC || wrLbaP || wrCmd || wrUnit
                          || wrMin || wrCfg || wrIStat || wrIMask
                          || (awAddr_q == OFF_COMMAND);
   wire         rdEn    = axiReq.arvalid && !rValid_q;
   logic [31:0] rdMux;
   logic        rdHit;

   always_comb begin
      rdHit = 1'b1;
      unique case (axiReq.araddr)
         OFF_FEAT:       rdMux = {16'h0, feat_q};
         OFF_COUNT:      rdMux = {16'h0, count_q};
         OFF_LBA_CUR:    rdMux = {8'h0, lbaCur_q};
         OFF_LBA_PREV:   rdMux = {8'h0, lbaPrev_q};
         OFF_COMMAND:    rdMux = 32'h0;
         OFF_STATUS:     rdMux = {16'h0, error_q, status_q};
         OFF_RES_LBA_LO: rdMux = {8'h0, resLba_q[23:0]};
         OFF_RES_LBA_HI: rdMux = {8'h0, resLba_q[47:24]};
         OFF_RES_COUNT:  rdMux = {16'h0, resCount_q};
         OFF_UNIT_TIME:  rdMux = unit_q;
         OFF_MIN_CCTL:   rdMux = minCctl_q;
         OFF_STREAM_CFG: rdMux = 32'h0;
         OFF_IRQ_STAT:   rdMux = {29'h0, irqStat_q};
         OFF_IRQ_MASK:   rdMux = {29'h0, irqMask_q};
         default: begin
            rdMux = 32'h0;
            rdHit = 1'b0;
         end
      endcase
   end

   assign axiRsp.awready = !awValid_q;
   assign axiRsp.wready  = !wValid_q;
   assign axiRsp.bvalid  = bValid_q;
   assign axiRsp.bresp   = bResp_q;
   assign axiRsp.arready = !rValid_q;
   assign axiRsp.rvalid  = rValid_q;
   assign axiRsp.rdata   = rData_q;
   assign axiRsp.rresp   = rResp_q;

   // ==========================================================
   // Bus channels
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         awValid_q <= 1'b0;
         awAddr_q  <= 8'h00;
      end else if (axiReq.awvalid && !awValid_q) begin
         awValid_q <= 1'b1;
         awAddr_q  <= {axiReq.awaddr[7:2], 2'b00};
      end else if (wrEn) begin
         awValid_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wValid_q <= 1'b0;
         wData_q  <= 32'h0;
         wStrb_q  <= 4'h0;
      end else if (axiReq.wvalid && !wValid_q) begin
         wValid_q <= 1'b1;
         wData_q  <= axiReq.wdata;
         wStrb_q  <= axiReq.wstrb;
      end else if (wrEn) begin
         wValid_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bValid_q <= 1'b0;
         bResp_q  <= RESP_OKAY;
      end else if (wrEn) begin
         bValid_q <= 1'b1;
         bResp_q  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (axiReq.bready) begin
         bValid_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rValid_q <= 1'b0;
         rData_q  <= 32'h0;
         rResp_q  <= RESP_OKAY;
      end else if (rdEn) begin
         rValid_q <= 1'b1;
         rData_q  <= rdMux;
         rResp_q  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (axiReq.rready) begin
         rValid_q <= 1'b0;
      end
   end

   // ==========================================================
   // Task file registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         feat_q    <= 16'h0;
         count_q   <= 16'h0;
         lbaCur_q  <= 24'h0;
         lbaPrev_q <= 24'h0;
         unit_q    <= UNIT_RESET;
         minCctl_q <= MIN_CCTL_RESET;
         irqMask_q <= 3'h0;
      end else begin
         if (wrFeat) feat_q <= wMerge[15:0] | (feat_q & ~{{8{wStrb_q[1]}}, {8{wStrb_q[0]}}});
         if (wrCount) count_q <= 16'(mergeBytes({16'h0, count_q}, wData_q, wStrb_q));
         if (wrLbaC) lbaCur_q <= 24'(mergeBytes({8'h0, lbaCur_q}, wData_q, wStrb_q));
         if (wrLbaP) lbaPrev_q <= 24'(mergeBytes({8'h0, lbaPrev_q}, wData_q, wStrb_q));
         if (wrUnit) unit_q <= mergeBytes(unit_q, wData_q, wStrb_q);
         if (wrMin) minCctl_q <= mergeBytes(minCctl_q, wData_q, wStrb_q);
         if (wrIMask) irqMask_q <= wData_q[2:0];
      end
   end

   // ==========================================================
   // Per-stream default limit
   rsx_stream_mem u_mem (
      .clk     (clk),
      .reset_n (reset_n),
      .we      (wrCfg),
      .wAddr   (wData_q[2:0]),
      .wData   (wData_q[15:8]),
      .rAddr   (feat_q[2:0]),
      .rData   (dfltCctl)
   );

   // ==========================================================
   // Command engine
   wire         idle      = state_q == S_IDLE;
   wire         startCmd  = wrCmd && idle && wData_q[7:0] == CMD_READ_STREAM;
   wire         badCmd    = wrCmd && idle && wData_q[7:0] != CMD_READ_STREAM;
   wire [7:0]   cctlSel   = feat_q[15:8] != 8'h0 ? feat_q[15:8] : dfltCctl;
   wire [39:0]  cctlRaw   = 40'(cctlSel) * 40'(unit_q);
   wire [39:0]  cctlClamp = cctlRaw < 40'(minCctl_q) ? 40'(minCctl_q) : cctlRaw;
   wire [47:0]  lbaStart  = {lbaPrev_q[23:16], lbaPrev_q[15:8], lbaPrev_q[7:0],
                             lbaCur_q[23:16], lbaCur_q[15:8], lbaCur_q[7:0]};
   wire         reading   = state_q == S_READ;
   wire         timeout   = reading && limitOn_q && elapsed_q >= limit_q;
   wire         secDone   = reading && !timeout && secRsp.ack;
   wire         secBad    = secDone && secRsp.err != 4'h0;
   wire         abortErr  = secBad && !rc_q;
   wire         lastSec   = secDone && !abortErr && remain_q == 17'h1;
   wire         finish    = timeout || abortErr || lastSec || badCmd;
   wire [2:0]   irqEvt    = {timeout, finish && reading && rc_q && (seenErr_q || secBad || timeout),
                             finish};

   assign secReq.valid    = reading;
   assign secReq.lba      = lba_q;
   assign secReq.streamId = feat_q[2:0];
   assign secReq.urgent   = feat_q[FEAT_URG];
   assign secReq.contin   = rc_q;
   assign irq             = |(irqStat_q & irqMask_q);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= S_IDLE;
      end else if (startCmd) begin
         state_q <= S_LOAD;
      end else if (state_q == S_LOAD) begin
         state_q <= S_READ;
      end else if (finish) begin
         state_q <= S_IDLE;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         remain_q  <= 17'h0;
         lba_q     <= 48'h0;
         rc_q      <= 1'b0;
         limit_q   <= 40'h0;
         limitOn_q <= 1'b0;
      end else if (state_q == S_LOAD) begin
         remain_q  <= count_q == 16'h0 ? FULL_COUNT : {1'b0, count_q};
         lba_q     <= lbaStart;
         rc_q      <= feat_q[FEAT_RC];
         limit_q   <= cctlClamp;
         limitOn_q <= cctlSel != 8'h0;
      end else if (secDone) begin
         remain_q <= remain_q - 17'h1;
         lba_q    <= lba_q + 48'h1;
      end
   end

   // Microsecond timer from the command write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         usDiv_q   <= 7'h0;
         elapsed_q <= 40'h0;
      end else if (startCmd) begin
         usDiv_q   <= 7'h0;
         elapsed_q <= 40'h0;
      end else if (!idle) begin
         usDiv_q   <= usDiv_q == CYC_PER_US - 7'h1 ? 7'h0 : usDiv_q + 7'h1;
         elapsed_q <= usDiv_q == CYC_PER_US - 7'h1 ? elapsed_q + 40'h1 : elapsed_q;
      end
   end

   // Error tracking in continuous mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         seenErr_q  <= 1'b0;
         runOpen_q  <= 1'b0;
         resLba_q   <= 48'h0;
         resCount_q <= 16'h0;
      end else if (startCmd) begin
         seenErr_q  <= 1'b0;
         runOpen_q  <= 1'b0;
         resLba_q   <= 48'h0;
         resCount_q <= 16'h0;
      end else if (secBad && rc_q) begin
         seenErr_q <= 1'b1;
         if (!seenErr_q) begin
            resLba_q   <= lba_q;
            resCount_q <= 16'h1;
            runOpen_q  <= 1'b1;
         end else if (runOpen_q) begin
            resCount_q <= resCount_q + 16'h1;
         end
      end else if (secDone) begin
         runOpen_q <= 1'b0;
      end
   end

   // Ending status and error log
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_q <= STATUS_RESET;
         error_q  <= 8'h00;
      end else if (startCmd) begin
         status_q <= 8'h88;
         error_q  <= 8'h00;
      end else if (badCmd) begin
         status_q <= 8'h41;
         error_q  <= 8'h04;
      end else if (reading) begin
         if (secBad) error_q <= error_q | errLog(secRsp.err);
         if (timeout) begin
            error_q[ER_CCTO] <= 1'b1;
            status_q <= rc_q ? 8'h60 : 8'h41;
         end else if (abortErr) begin
            status_q <= 8'h41;
         end else if (lastSec) begin
            status_q <= (seenErr_q || secBad) ? 8'h60 : 8'h40;
         end
      end
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irqStat_q <= 3'h0;
      end else begin
         irqStat_q <= (irqStat_q & ~(wrIStat ? wData_q[2:0] : 3'h0)) | irqEvt;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_decode;
      wrCmd && idle && wData_q[7:0] == CMD_READ_STREAM |=> state_q == S_LOAD ##1 reading;
   endproperty
   a_decode: assert property (p_decode) else $error("opcode not decoded");

   property p_count0;
      state_q == S_LOAD && count_q == 16'h0 |=> remain_q == 17'h10000;
   endproperty
   a_count0: assert property (p_count0) else $error("zero count wrong");

   property p_normal_abort;
      reading && !rc_q && !timeout && secRsp.ack && secRsp.err != 4'h0
         |=> idle && status_q[ST_ERR] && !status_q[ST_BSY];
   endproperty
   a_normal_abort: assert property (p_normal_abort) else $error("no abort");

   property p_rc_continue;
      reading && rc_q && !timeout && secRsp.ack && secRsp.err != 4'h0 && remain_q > 17'h1
         |=> reading && !status_q[ST_ERR];
   endproperty
   a_rc_continue: assert property (p_rc_continue) else $error("rc stopped");

   property p_rc_end;
      reading && rc_q && lastSec && (seenErr_q || secBad)
         |=> status_q[ST_SE] && !status_q[ST_ERR] && !status_q[ST_BSY];
   endproperty
   a_rc_end: assert property (p_rc_end) else $error("rc end status");

   property p_rc_timeout;
      timeout && rc_q |=> idle && error_q[ER_CCTO] && status_q[ST_SE] && !status_q[ST_ERR];
   endproperty
   a_rc_timeout: assert property (p_rc_timeout) else $error("timeout status");

   property p_limit;
      state_q == S_LOAD && feat_q[15:8] != 8'h0
         |=> limitOn_q && limit_q >= 40'($past(minCctl_q))
             && (limit_q == 40'($past(feat_q[15:8])) * 40'($past(unit_q))
                 || limit_q == 40'($past(minCctl_q)));
   endproperty
   a_limit: assert property (p_limit) else $error("limit wrong");

   property p_lba;
      state_q == S_LOAD |=> secReq.lba == $past(lbaStart) && secReq.valid;
   endproperty
   a_lba: assert property (p_lba) else $error("start lba wrong");

   property p_first_err;
      reading && rc_q && secBad && !seenErr_q |=> resLba_q == $past(lba_q) && resCount_q == 16'h1;
   endproperty
   a_first_err: assert property (p_first_err) else $error("first error lba");
endmodule

/* File: design/rsx_stream_mem.sv */
`timescale 1ns/1ps
module rsx_stream_mem (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Write side
   input  wire logic       we,
   input  wire logic [2:0] wAddr,
   input  wire logic [7:0] wData,
   // Read side
   input  wire logic [2:0] rAddr,
   output logic [7:0]      rData
);
   logic [7:0] mem [8];

   // ==========================================================
   // Storage
   always_ff @(posedge clk) begin
      if (we) begin
         mem[wAddr] <= wData;
      end
   end

   // ==========================================================
   // Registered read
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rData <= 8'h00;
      end else begin
         rData <= mem[rAddr];
      end
   end
endmodule

/* File: include/rsx_pkg.sv */
package rsx_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] OFF_FEAT       = 8'h00;
   localparam logic [7:0] OFF_COUNT      = 8'h04;
   localparam logic [7:0] OFF_LBA_CUR    = 8'h08;
   localparam logic [7:0] OFF_LBA_PREV   = 8'h0C;
   localparam logic [7:0] OFF_COMMAND    = 8'h10;
   localparam logic [7:0] OFF_STATUS     = 8'h14;
   localparam logic [7:0] OFF_RES_LBA_LO = 8'h18;
   localparam logic [7:0] OFF_RES_LBA_HI = 8'h1C;
   localparam logic [7:0] OFF_RES_COUNT  = 8'h20;
   localparam logic [7:0] OFF_UNIT_TIME  = 8'h24;
   localparam logic [7:0] OFF_MIN_CCTL   = 8'h28;
   localparam logic [7:0] OFF_STREAM_CFG = 8'h2C;
   localparam logic [7:0] OFF_IRQ_STAT   = 8'h30;
   localparam logic [7:0] OFF_IRQ_MASK   = 8'h34;

   // ==========================================================
   // Command and field positions
   localparam logic [7:0]  CMD_READ_STREAM = 8'h2B;
   localparam int          FEAT_URG        = 7;
   localparam int          FEAT_RC         = 6;
   localparam int          ST_BSY          = 7;
   localparam int          ST_RDY          = 6;
   localparam int          ST_SE           = 5;
   localparam int          ST_DRQ          = 3;
   localparam int          ST_ERR          = 0;
   localparam int          ER_CRC          = 7;
   localparam int          ER_UNC          = 6;
   localparam int          ER_IDN          = 4;
   localparam int          ER_ABT          = 2;
   localparam int          ER_CCTO         = 0;
   localparam int          IRQ_DONE        = 0;
   localparam int          IRQ_SE          = 1;
   localparam int          IRQ_TMO         = 2;
   localparam logic [16:0] FULL_COUNT      = 17'h10000;
   localparam logic [7:0]  STATUS_RESET    = 8'h40;
   localparam logic [31:0] UNIT_RESET      = 32'h0000_0001;
   localparam logic [31:0] MIN_CCTL_RESET  = 32'h0000_0001;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ==========================================================
   // Timing
   localparam int         CLK_PERIOD_NS = 8;
   localparam int         US_NS         = 1000;
   localparam logic [6:0] CYC_PER_US    = 7'(US_NS / CLK_PERIOD_NS);

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_LOAD = 2'b01,
      S_READ = 2'b10
   } rsx_state_e;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } rsx_axil_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } rsx_axil_rsp_s;

   // Sector request to the media engine
   typedef struct packed {
      logic        valid;
      logic [47:0] lba;
      logic [2:0]  streamId;
      logic        urgent;
      logic        contin;
   } rsx_sec_req_s;

   // Sector result: err = {abrt, idnf, unc, crc}
   typedef struct packed {
      logic       ack;
      logic [3:0] err;
   } rsx_sec_rsp_s;

endpackage

/* File: testbench/rsx_media_model.sv */
`timescale 1ns/1ps
module rsx_media_model
   import rsx_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Sector request and answer
   input  rsx_pkg::rsx_sec_req_s secReq,
   output rsx_pkg::rsx_sec_rsp_s secRsp,
   // Scenario control
   input  wire logic [15:0]      badMap,
   input  wire logic [3:0]       errCode,
   input  wire logic [3:0]       waitCycles,
   input  wire logic             stall
);
   import rsx_pkg::*;
   // ==========================================================
   // Sector timing
   logic [3:0] waitCnt_q;
   logic [3:0] waitCnt_d;
   logic       hit;
   assign hit        = secReq.valid & ~stall & (waitCnt_q == waitCycles);
   assign waitCnt_d  = (!secReq.valid || hit) ? 4'h0 : waitCnt_q + 4'h1;
   assign secRsp.ack = hit;
   // Error flags only count with ack, so they churn otherwise
   assign secRsp.err = hit ? (badMap[secReq.lba[3:0]] ? errCode : 4'h0) : ~waitCnt_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         waitCnt_q <= 4'h0;
      end else begin
         waitCnt_q <= waitCnt_d;
      end
   end
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
   import rsx_pkg::*;
   // ==========================================================
   // Signals and instances
   logic          clk;
   logic          resetN;
   rsx_axil_req_s req;
   rsx_axil_rsp_s rsp;
   rsx_sec_req_s  secReq;
   rsx_sec_rsp_s  secRsp;
   logic          irq;
   logic [15:0]   badMap;
   logic [3:0]    errCode;
   logic [3:0]    waitCycles;
   logic          stall;
   logic [31:0]   rd;
   logic [1:0]    rr;
   int            fails = 0;
   int            samplesChecked = 0;
   int            ackCnt = 0;
   int            cyc = 0;

   rsx_read_stream i_dut (.clk(clk), .reset_n(resetN), .axiReq(req), .axiRsp(rsp),
                          .secReq(secReq), .secRsp(secRsp), .irq(irq));
   rsx_media_model i_media (.clk(clk), .reset_n(resetN), .secReq(secReq), .secRsp(secRsp),
                            .badMap(badMap), .errCode(errCode), .waitCycles(waitCycles),
                            .stall(stall));

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (secReq.valid === 1'b1 && secRsp.ack === 1'b1) ackCnt <= ackCnt + 1;
   end

   // ==========================================================
   // Bus and check tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      do begin
         @(negedge clk);
         ta = req.awvalid & rsp.awready;
         tw = req.wvalid & rsp.wready;
         tb = rsp.bvalid;
         rr = rsp.bresp;
         @(posedge clk);
         if (ta) req.awvalid <= 1'b0;
         if (tw) req.wvalid <= 1'b0;
      end while (tb !== 1'b1);
      req.bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic axr(input logic [7:0] a);
      logic ta, tr;
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      do begin
         @(negedge clk);
         ta = req.arvalid & rsp.arready;
         tr = rsp.rvalid;
         rd = rsp.rdata;
         rr = rsp.rresp;
         @(posedge clk);
         if (ta) req.arvalid <= 1'b0;
      end while (tr !== 1'b1);
      req.rready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic issue(input logic [15:0] f, input logic [15:0] n, input logic [23:0] lo,
                        input logic [23:0] hi, input logic [7:0] op);
      axw(OFF_IRQ_STAT, 32'h7);
      axw(OFF_FEAT, {16'h0, f});
      axw(OFF_COUNT, {16'h0, n});
      axw(OFF_LBA_CUR, {8'h0, lo});
      axw(OFF_LBA_PREV, {8'h0, hi});
      axw(OFF_COMMAND, {24'h0, op});
   endtask

   task automatic finish_cmd(input string what, input logic [15:0] expSt);
      int n;
      n = 0;
      do begin
         axr(OFF_STATUS);
         n++;
      end while (rd[ST_BSY] !== 1'b0 && n < 30000);
      chk(what, rd, {16'h0, expSt});
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      axr(OFF_STATUS);
      chk("status", rd, 32'h0000_0040);
      axr(8'h3C);
      chk("unmapped resp", {30'h0, rr}, {30'h0, RESP_SLVERR});
      chk("unmapped data", rd, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      axw(OFF_STREAM_CFG, 32'h0);
      axw(OFF_STREAM_CFG, 32'h5);
      chk("write resp", {30'h0, rr}, {30'h0, RESP_OKAY});
      axw(8'h3C, 32'h1);
      chk("unmapped wr resp", {30'h0, rr}, {30'h0, RESP_SLVERR});
      axw(OFF_IRQ_MASK, 32'h7);
      $display("test reset done");
   endtask

   task automatic t_normal;
      int a0, n;
      a0 = ackCnt;
      n = 0;
      issue(16'h0000, 16'h0003, 24'h123456, 24'hABCDEF, CMD_READ_STREAM);
      while (secReq.valid !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk("lba low", secReq.lba[31:0], 32'hEF12_3456);
      chk("lba high", {16'h0, secReq.lba[47:32]}, 32'h0000_ABCD);
      chk("normal contin", {31'h0, secReq.contin}, 32'h0);
      @(posedge clk);
      finish_cmd("normal status", 16'h0040);
      chk("normal sectors", 32'(ackCnt - a0), 32'd3);
      chk("irq set", {31'h0, irq}, 32'h1);
      axw(OFF_IRQ_STAT, 32'h1);
      chk("irq clear", {31'h0, irq}, 32'h0);
      $display("test normal done");
   endtask

   task automatic t_rc;
      int a0;
      a0 = ackCnt;
      badMap  <= 16'h0006;
      errCode <= 4'b0010;
      issue(16'h0040, 16'h0004, 24'h000010, 24'h0, CMD_READ_STREAM);
      chk("rc contin", {31'h0, secReq.contin}, 32'h1);
      finish_cmd("rc status", 16'h4060);
      chk("rc sectors", 32'(ackCnt - a0), 32'd4);
      axr(OFF_RES_LBA_LO);
      chk("first bad lba", rd, 32'h0000_0011);
      axr(OFF_RES_COUNT);
      chk("bad run", rd, 32'h2);
      axr(OFF_IRQ_STAT);
      chk("irq status", rd, 32'h3);
      $display("test rc done");
   endtask

   task automatic t_abort;
      int a0;
      a0 = ackCnt;
      errCode <= 4'b0001;
      issue(16'h0000, 16'h0004, 24'h000010, 24'h0, CMD_READ_STREAM);
      finish_cmd("abort status", 16'h8041);
      chk("abort sectors", 32'(ackCnt - a0), 32'd2);
      issue(16'h0000, 16'h0001, 24'h0, 24'h0, 8'h20);
      finish_cmd("bad opcode", 16'h0441);
      badMap <= 16'h0;
      $display("test abort done");
   endtask

   task automatic t_tmo;
      int t0, n;
      n = 0;
      stall <= 1'b1;
      axw(OFF_MIN_CCTL, 32'h2);
      issue(16'h01C5, 16'h0001, 24'h0, 24'h0, CMD_READ_STREAM);
      t0 = cyc;
      chk("urgent", {31'h0, secReq.urgent}, 32'h1);
      chk("stream id", {29'h0, secReq.streamId}, 32'h5);
      while (secReq.valid !== 1'b0 && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk("limit clamp", {31'h0, (cyc - t0 >= 243) && (cyc - t0 <= 253)}, 32'h1);
      @(posedge clk);
      finish_cmd("timeout status", 16'h0160);
      stall <= 1'b0;
      $display("test timeout done");
   endtask

   task automatic t_full;
      int a0;
      a0 = ackCnt;
      waitCycles <= 4'd0;
      issue(16'h0000, 16'h0000, 24'h0, 24'h0, CMD_READ_STREAM);
      finish_cmd("full status", 16'h0040);
      chk("full sectors", 32'(ackCnt - a0), 32'd65536);
      $display("test full count done");
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Clock, sequence and watchdog
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      resetN = 1'b0;
      req = '0;
      badMap = 16'h0;
      errCode = 4'h0;
      waitCycles = 4'd2;
      stall = 1'b0;
      repeat (3) @(posedge clk);
      resetN <= 1'b1;
      @(posedge clk);
      t_reset;
      t_normal;
      t_rc;
      t_abort;
      t_tmo;
      t_full;
      tally_and_finish;
   end

   initial begin
      repeat (95000) @(posedge clk);
      fails++;
      tally_and_finish;
   end
endmodule
